// ==== src/ascii_dio_pkg.sv ====
// Constants and types for the ASCII digital-input command interpreter
package ascii_dio_pkg;
    // ==========================================================
    // Clock and line rates
    localparam int CLK_HZ = 50_000_000;
    localparam int BAUD_1200 = 1200;
    localparam int BAUD_2400 = 2400;
    localparam int BAUD_4800 = 4800;
    localparam int BAUD_9600 = 9600;
    localparam int BAUD_19200 = 19200;
    localparam int BAUD_38400 = 38400;
    localparam logic [7:0] RATE_1200 = 8'h03;
    localparam logic [7:0] RATE_2400 = 8'h04;
    localparam logic [7:0] RATE_4800 = 8'h05;
    localparam logic [7:0] RATE_9600 = 8'h06;
    localparam logic [7:0] RATE_19200 = 8'h07;
    localparam logic [7:0] RATE_38400 = 8'h08;
    // ==========================================================
    // Characters
    localparam logic [7:0] CHAR_CR = 8'h0D;
    localparam logic [7:0] CHAR_DOLLAR = 8'h24;
    localparam logic [7:0] CHAR_PERCENT = 8'h25;
    localparam logic [7:0] CHAR_HASH = 8'h23;
    localparam logic [7:0] CHAR_AT = 8'h40;
    localparam logic [7:0] CHAR_BANG = 8'h21;
    localparam logic [7:0] CHAR_QUERY = 8'h3F;
    localparam logic [7:0] CHAR_ZERO = 8'h30;
    localparam logic [7:0] CHAR_SIX = 8'h36;
    // ==========================================================
    // Frame layout and fields
    localparam int BUF_DEPTH = 13;
    localparam logic [3:0] QUERY_LEN = 4'h4;
    localparam logic [3:0] CONFIG_LEN = 4'hB;
    localparam logic [3:0] MIN_LEN = 4'h3;
    localparam logic [7:0] TYPE_CODE = 8'h00;
    localparam int FMT_CK_BIT = 6;
    localparam logic [7:0] FMT_RSVD_MASK = 8'hBF;
    localparam logic [7:0] DEFAULT_ADDR = 8'h00;
    localparam logic [7:0] FACTORY_ADDR = 8'h01;
    // ==========================================================
    // Bit-level framing states, Gray along the usual path
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_DATA  = 2'b11,
        ST_STOP  = 2'b10
    } bit_state_e;

    // Clocks per bit for a rate code; unknown codes fall back to 9600
    function automatic logic [15:0] bitClocks(input logic [7:0] code, input int clkHz);
        int baud;
        case (code)
            RATE_1200: baud = BAUD_1200;
            RATE_2400: baud = BAUD_2400;
            RATE_4800: baud = BAUD_4800;
            RATE_19200: baud = BAUD_19200;
            RATE_38400: baud = BAUD_38400;
            default: baud = BAUD_9600;
        endcase
        return 16'(clkHz / baud);
    endfunction
endpackage

// ==== src/ascii_dio_command_interpreter.sv ====
// ASCII addressed command interpreter for eight digital inputs
// Operation
// - Frame: leader, two hex address chars, command, data, optional checksum, CR.
// - With checksum enabled, commands and replies carry two checksum chars before CR.
// - Checksum is byte sum of all preceding chars, sent as two hex chars.
// - Replies start with '!' when accepted, '?' when rejected.
// - Input query is '$', address, '6', CR.
// - Each address nibble travels as its ASCII hex character.
// - Query reply: '!', two hex chars of inputs, "0000", CR.
// - Reported bit n is channel n; one means high.
// - Format errors, line errors or foreign addresses get no reply.
// - Addressed but invalid request answers '?', own address, CR.
// - Config command: '%', address, new address, type, rate, format, CR; stored.
// - Type field must be 00.
// - Rate codes 03..08 select 1200 to 38400 baud.
// - Format bit 6 enables checksums.
// - Config answers '!'+new address, or '?' if illegal or unguarded rate/checksum change.
// - Characters: one start, eight data, one stop bit, no parity.
// - Default switch at power-up forces address 00, 9600 baud, no checksum.
// - Blank storage means address 01, 9600 baud, checksum off.
`timescale 1ns/10ps
module ascii_dio_command_interpreter #(
    parameter int CLK_HZ = ascii_dio_pkg::CLK_HZ  // Clock rate, sets every bit time
) (
    input  wire logic       ref_clk,         // System clock, 50 MHz
    input  wire logic       rst_n,           // Asynchronous reset, active low
    input  wire logic       rxLine,          // Serial receive data, idle high
    output logic            txLine,          // Serial transmit data, idle high
    output logic            txEnable,        // Line driver enable during a reply
    input  wire logic [7:0] inputLevels,     // Channel levels, bit n is channel n
    input  wire logic       defaultSwitch,   // Default-setting switch, sampled once
    input  wire logic       storedValid,     // Nonvolatile storage holds a setting
    input  wire logic [7:0] storedAddr,      // Stored node address
    input  wire logic [7:0] storedRateCode,  // Stored rate code
    input  wire logic       storedChecksum,  // Stored checksum enable
    output logic            storeWrite,      // One-cycle request to save settings
    output logic [7:0]      storeAddr,       // Address to save
    output logic [7:0]      storeRateCode,   // Rate code to save
    output logic            storeChecksum,   // Checksum enable to save
    output logic [7:0]      nodeAddr,        // Address in use
    output logic [7:0]      rateCode,        // Rate code in use
    output logic            checksumOn,      // Checksum use in force
    output logic            defaultMode      // Started with the default switch
);
    // ==========================================================
    // Helpers
    // Uppercase-only hex decode; bit 4 flags a valid digit
    // uppercase hex only
    function automatic logic [4:0] hexVal(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39)
            return {1'b1, c[3:0]};
        else if (c >= 8'h41 && c <= 8'h46)
            return {1'b1, 4'(c[3:0] + 4'h9)};
        else
            return 5'h00;
    endfunction

    // Two hex chars to {valid, byte}
    // ASCII hex address pair
    function automatic logic [8:0] hexPair(input logic [7:0] hi, input logic [7:0] lo);
        logic [4:0] h;
        logic [4:0] l;
        h = hexVal(hi);
        l = hexVal(lo);
        return {h[4] & l[4], h[3:0], l[3:0]};
    endfunction

    function automatic logic [7:0] hexChar(input logic [3:0] n);
        return (n < 4'hA) ? 8'(8'h30 + n) : 8'(8'h37 + n);
    endfunction

    // ==========================================================
    // Configuration
    logic       loaded;
    logic       pending;
    logic [7:0] pendAddr;
    logic [7:0] pendRate;
    logic       pendCk;
    logic       txDone;
    wire  [7:0] startAddr = storedValid ? storedAddr : ascii_dio_pkg::FACTORY_ADDR;
    wire  [7:0] startRate = storedValid ? storedRateCode : ascii_dio_pkg::RATE_9600;
    wire        startCk = storedValid & storedChecksum;

    // Settings caught on the first edge after reset release
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loaded <= 1'b0;
            defaultMode <= 1'b0;
            nodeAddr <= ascii_dio_pkg::FACTORY_ADDR;
            rateCode <= ascii_dio_pkg::RATE_9600;
            checksumOn <= 1'b0;
        end
        else if (!loaded)
        begin
            loaded <= 1'b1;
            defaultMode <= defaultSwitch;
            nodeAddr <= defaultSwitch ? ascii_dio_pkg::DEFAULT_ADDR : startAddr;
            rateCode <= defaultSwitch ? ascii_dio_pkg::RATE_9600 : startRate;
            checksumOn <= defaultSwitch ? 1'b0 : startCk;
        end
        else if (txDone && pending)
        begin
            nodeAddr <= pendAddr;
            rateCode <= pendRate;
            checksumOn <= pendCk;
        end
    end

    wire [15:0] bitLen = ascii_dio_pkg::bitClocks(rateCode, CLK_HZ);

    // ==========================================================
    // Receiver
    ascii_dio_pkg::bit_state_e rxState;
    logic [15:0] rxCnt;
    logic [2:0]  rxBit;
    logic [7:0]  rxShift;
    logic        rxValid;
    logic        rxErr;

    // start, 8 data LSB first, stop
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxState <= ascii_dio_pkg::ST_IDLE;
            rxCnt <= 16'h0000;
            rxBit <= 3'h0;
            rxShift <= 8'h00;
            rxValid <= 1'b0;
            rxErr <= 1'b0;
        end
        else
        begin
            rxValid <= 1'b0;
            rxErr <= 1'b0;
            rxCnt <= rxCnt + 16'h0001;
            case (rxState)
                ascii_dio_pkg::ST_IDLE:
                begin
                    rxCnt <= 16'h0000;
                    if (!rxLine && loaded)
                        rxState <= ascii_dio_pkg::ST_START;
                end
                ascii_dio_pkg::ST_START:
                    if (rxCnt >= {1'b0, bitLen[15:1]})
                    begin
                        rxCnt <= 16'h0000;
                        rxBit <= 3'h0;
                        // Glitch shorter than half a bit is not a start
                        rxState <= rxLine ? ascii_dio_pkg::ST_IDLE : ascii_dio_pkg::ST_DATA;
                    end
                ascii_dio_pkg::ST_DATA:
                    if (rxCnt >= bitLen - 16'h0001)
                    begin
                        rxCnt <= 16'h0000;
                        rxShift <= {rxLine, rxShift[7:1]};
                        rxBit <= rxBit + 3'h1;
                        if (rxBit == 3'h7)
                            rxState <= ascii_dio_pkg::ST_STOP;
                    end
                ascii_dio_pkg::ST_STOP:
                    if (rxCnt >= bitLen - 16'h0001)
                    begin
                        rxValid <= rxLine;
                        rxErr <= !rxLine;
                        rxState <= ascii_dio_pkg::ST_IDLE;
                    end
                default: rxState <= ascii_dio_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Frame collector
    logic [7:0] frame [ascii_dio_pkg::BUF_DEPTH];
    logic [3:0] count;
    logic       active;
    logic       bad;
    logic       evalGo;
    logic [7:0] sum0;
    logic [7:0] sum1;
    logic [7:0] sum2;
    wire isLeader = rxShift == ascii_dio_pkg::CHAR_DOLLAR || rxShift == ascii_dio_pkg::CHAR_PERCENT
                 || rxShift == ascii_dio_pkg::CHAR_HASH || rxShift == ascii_dio_pkg::CHAR_AT;
    wire isCr = rxShift == ascii_dio_pkg::CHAR_CR;

    // Running sums lag by two so the received checksum is excluded
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < ascii_dio_pkg::BUF_DEPTH; i++)
                frame[i] <= 8'h00;
            count <= 4'h0;
            active <= 1'b0;
            bad <= 1'b0;
            evalGo <= 1'b0;
            sum0 <= 8'h00;
            sum1 <= 8'h00;
            sum2 <= 8'h00;
        end
        else
        begin
            evalGo <= rxValid && active && isCr;
            if (rxValid && isLeader)
            begin
                frame[0] <= rxShift;
                count <= 4'h1;
                active <= 1'b1;
                bad <= 1'b0;
                sum0 <= rxShift;
                sum1 <= 8'h00;
                sum2 <= 8'h00;
            end
            else if (rxValid && active && isCr)
                active <= 1'b0;
            else if (rxValid && active)
            begin
                if (count < 4'(ascii_dio_pkg::BUF_DEPTH))
                begin
                    frame[count] <= rxShift;
                    count <= count + 4'h1;
                end
                else
                    bad <= 1'b1;
                // byte sum, wraps at 8 bits
                sum0 <= sum0 + rxShift;
                sum1 <= sum0;
                sum2 <= sum1;
            end
            else if (rxErr && active)
                bad <= 1'b1;
        end
    end

    // ==========================================================
    // Frame decode
    wire [3:0] ckPos = count - 4'h2;
    wire [8:0] ckPair = hexPair(frame[ckPos], frame[4'(ckPos + 4'h1)]);
    wire       ckOk = !checksumOn || (count >= 4'h5 && ckPair[8] && ckPair[7:0] == sum2);
    wire [3:0] msgLen = checksumOn ? ckPos : count;
    wire [8:0] addrPair = hexPair(frame[1], frame[2]);
    wire       formatOk = !bad && ckOk && msgLen >= ascii_dio_pkg::MIN_LEN && addrPair[8];
    wire       hit = formatOk && addrPair[7:0] == nodeAddr;
    wire       isQuery = frame[0] == ascii_dio_pkg::CHAR_DOLLAR
                      && msgLen == ascii_dio_pkg::QUERY_LEN && frame[3] == ascii_dio_pkg::CHAR_SIX;
    wire [8:0] newPair = hexPair(frame[3], frame[4]);
    wire [8:0] typePair = hexPair(frame[5], frame[6]);
    wire [8:0] ratePair = hexPair(frame[7], frame[8]);
    wire [8:0] fmtPair = hexPair(frame[9], frame[10]);
    wire       newCk = fmtPair[ascii_dio_pkg::FMT_CK_BIT];
    wire       cfgLegal = frame[0] == ascii_dio_pkg::CHAR_PERCENT
                       && msgLen == ascii_dio_pkg::CONFIG_LEN
                       && newPair[8] && typePair[8] && ratePair[8] && fmtPair[8]
                       && typePair[7:0] == ascii_dio_pkg::TYPE_CODE
                       && ratePair[7:0] >= ascii_dio_pkg::RATE_1200
                       && ratePair[7:0] <= ascii_dio_pkg::RATE_38400
                       && (fmtPair[7:0] & ascii_dio_pkg::FMT_RSVD_MASK) == 8'h00;
    wire       cfgOk = cfgLegal
                    && (defaultMode || (ratePair[7:0] == rateCode && newCk == checksumOn));
    logic      txActive;
    // silent unless well formed and ours
    wire       loadReply = evalGo && hit && !txActive;

    // Reply body; checksum and CR are added by the sender
    logic [7:0] next_reply [7];
    logic [3:0] next_len;
    always_comb
    begin
        for (int i = 0; i < 7; i++)
            next_reply[i] = ascii_dio_pkg::CHAR_ZERO;
        // lead char marks accept or reject
        next_reply[0] = ascii_dio_pkg::CHAR_QUERY;
        next_reply[1] = hexChar(nodeAddr[7:4]);
        next_reply[2] = hexChar(nodeAddr[3:0]);
        next_len = 4'h3;
        if (isQuery)
        begin
            next_reply[0] = ascii_dio_pkg::CHAR_BANG;
            next_reply[1] = hexChar(inputLevels[7:4]);
            next_reply[2] = hexChar(inputLevels[3:0]);
            next_len = 4'h7;
        end
        else if (cfgOk)
        begin
            next_reply[0] = ascii_dio_pkg::CHAR_BANG;
            next_reply[1] = hexChar(newPair[7:4]);
            next_reply[2] = hexChar(newPair[3:0]);
        end
    end

    // ==========================================================
    // Transmitter
    ascii_dio_pkg::bit_state_e txState;
    logic [7:0]  reply [7];
    logic [3:0]  replyLen;
    logic [3:0]  txIdx;
    logic [7:0]  txShift;
    logic [7:0]  txSum;
    logic [15:0] txCnt;
    logic [2:0]  txBit;
    wire  [3:0]  lastIdx = replyLen + (checksumOn ? 4'h2 : 4'h0);
    wire  [7:0]  curChar = (txIdx < replyLen) ? reply[txIdx[2:0]]
                         : (txIdx == lastIdx) ? ascii_dio_pkg::CHAR_CR
                         : (txIdx == replyLen) ? hexChar(txSum[7:4]) : hexChar(txSum[3:0]);
    assign txDone = txActive && txState == ascii_dio_pkg::ST_STOP
                 && txCnt >= bitLen - 16'h0001 && txIdx == lastIdx;
    assign txEnable = txActive;
    assign txLine = txState == ascii_dio_pkg::ST_START ? 1'b0
                  : txState == ascii_dio_pkg::ST_DATA ? txShift[0] : 1'b1;

    // Reply capture and pending settings
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 7; i++)
                reply[i] <= 8'h00;
            replyLen <= 4'h0;
            pending <= 1'b0;
            pendAddr <= 8'h00;
            pendRate <= 8'h00;
            pendCk <= 1'b0;
            storeWrite <= 1'b0;
            storeAddr <= 8'h00;
            storeRateCode <= 8'h00;
            storeChecksum <= 1'b0;
        end
        else
        begin
            storeWrite <= txDone && pending;
            if (txDone)
                pending <= 1'b0;
            if (loadReply)
            begin
                reply <= next_reply;
                replyLen <= next_len;
                pending <= cfgOk && !isQuery;
                pendAddr <= newPair[7:0];
                pendRate <= ratePair[7:0];
                pendCk <= newCk;
                storeAddr <= newPair[7:0];
                storeRateCode <= ratePair[7:0];
                storeChecksum <= newCk;
            end
        end
    end

    // Character sequencer and bit shifter
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txState <= ascii_dio_pkg::ST_IDLE;
            txActive <= 1'b0;
            txIdx <= 4'h0;
            txShift <= 8'hFF;
            txSum <= 8'h00;
            txCnt <= 16'h0000;
            txBit <= 3'h0;
        end
        else
        begin
            txCnt <= txCnt + 16'h0001;
            case (txState)
                ascii_dio_pkg::ST_IDLE:
                begin
                    txCnt <= 16'h0000;
                    if (loadReply)
                    begin
                        txActive <= 1'b1;
                        txIdx <= 4'h0;
                        txSum <= 8'h00;
                    end
                    else if (txActive)
                    begin
                        txShift <= curChar;
                        if (txIdx < replyLen)
                            txSum <= txSum + curChar;
                        txState <= ascii_dio_pkg::ST_START;
                    end
                end
                ascii_dio_pkg::ST_START:
                    if (txCnt >= bitLen - 16'h0001)
                    begin
                        txCnt <= 16'h0000;
                        txBit <= 3'h0;
                        txState <= ascii_dio_pkg::ST_DATA;
                    end
                ascii_dio_pkg::ST_DATA:
                    if (txCnt >= bitLen - 16'h0001)
                    begin
                        txCnt <= 16'h0000;
                        txShift <= {1'b1, txShift[7:1]};
                        txBit <= txBit + 3'h1;
                        if (txBit == 3'h7)
                            txState <= ascii_dio_pkg::ST_STOP;
                    end
                ascii_dio_pkg::ST_STOP:
                    if (txCnt >= bitLen - 16'h0001)
                    begin
                        txState <= ascii_dio_pkg::ST_IDLE;
                        txIdx <= txIdx + 4'h1;
                        if (txIdx == lastIdx)
                            txActive <= 1'b0;
                    end
                default: txState <= ascii_dio_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Checks
    a_tx_idle_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !txActive |-> txLine) else $error("line not idle high");
    a_reply_first_char: assert property (@(posedge ref_clk) disable iff (!rst_n)
        loadReply |=> reply[0] == 8'h21 || reply[0] == 8'h3F) else $error("bad lead");
    a_foreign_silent: assert property (@(posedge ref_clk) disable iff (!rst_n)
        evalGo && !hit && !txActive |=> !txActive) else $error("reply to foreign frame");
    a_apply_after_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
        loaded && $past(loaded) && $changed(nodeAddr) |-> $past(txDone)) else $error("early");
    a_last_char_cr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        txActive && txState == ascii_dio_pkg::ST_IDLE && txIdx == lastIdx && !loadReply
        |=> txShift == 8'h0D) else $error("no CR last");
    a_default_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(loaded) && defaultMode |-> nodeAddr == 8'h00 && rateCode == 8'h06 && !checksumOn)
        else $error("default start wrong");
    a_status_hex: assert property (@(posedge ref_clk) disable iff (!rst_n)
        loadReply && isQuery |=> reply[1] == hexChar($past(inputLevels[7:4]))
        && reply[3] == 8'h30 && replyLen == 4'h7) else $error("status reply wrong");
    a_guarded_change: assert property (@(posedge ref_clk) disable iff (!rst_n)
        storeWrite && (storeRateCode != $past(rateCode)) |-> defaultMode) else $error("unguarded");
    a_leader_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rxValid && isLeader |=> count == 4'h1 && active) else $error("no restart");
endmodule

// ==== verif/host_uart.sv ====
// Host side serial model: sends command bytes, collects reply bytes
`timescale 1ns/10ps
module host_uart (
    input  wire logic ref_clk, // System clock
    output logic      rxLine,  // Line into the device, idle high
    input  wire logic txLine   // Line from the device
);
    int bitLen = 5208; // Clocks per bit at the rate in force
    // ==========================================
    // Character framing
    // start, data LSB first, stop
    task automatic sendByte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge ref_clk) rxLine <= f[i];
            repeat (bitLen - 1) @(posedge ref_clk);
        end
    endtask
    // Returns mid stop bit so a back-to-back start is still seen
    task automatic getByte(output logic [7:0] b, output bit seen);
        int t;
        t = 0;
        b = 8'h00;
        while (txLine === 1'b1 && t < 150 * bitLen)
        begin
            @(posedge ref_clk);
            t++;
        end
        seen = (txLine === 1'b0);
        if (seen)
        begin
            repeat (bitLen / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (bitLen) @(posedge ref_clk);
                b[i] = txLine;
            end
            repeat (bitLen) @(posedge ref_clk);
        end
    endtask
    initial rxLine = 1'b1;
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the ASCII digital-input interpreter
`timescale 1ns/10ps
module testbench;
    // Scaled clock rate told to the design, so every line rate fits a short run
    localparam int BENCH_HZ = 384_000;
    logic       ref_clk;
    logic       rst_n;
    logic       defaultSwitch;
    logic       storedValid;
    logic [7:0] inputLevels;
    wire logic  rxLine;
    wire logic  txLine;
    wire logic  txEnable;
    wire logic  checksumOn;
    wire logic  storeChecksum;
    wire logic  storeWrite;
    wire logic  defaultMode;
    wire logic [7:0] nodeAddr;
    wire logic [7:0] rateCode;
    wire logic [7:0] storeAddr;
    wire logic [7:0] storeRateCode;
    int error_cnt = 0;
    int samples_checked = 0;
    int writeCnt = 0;

    host_uart hostU (.ref_clk(ref_clk), .rxLine(rxLine), .txLine(txLine));
    // Stored setting 5A, 19200, checksum on: used only with the switch off
    ascii_dio_command_interpreter #(.CLK_HZ(BENCH_HZ)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .rxLine(rxLine), .txLine(txLine),
        .txEnable(txEnable), .inputLevels(inputLevels), .defaultSwitch(defaultSwitch),
        .storedValid(storedValid), .storedAddr(8'h5A), .storedRateCode(8'h07),
        .storedChecksum(1'b1), .storeWrite(storeWrite), .storeAddr(storeAddr),
        .storeRateCode(storeRateCode), .storeChecksum(storeChecksum), .nodeAddr(nodeAddr),
        .rateCode(rateCode), .checksumOn(checksumOn), .defaultMode(defaultMode));

    // Save pulses counted on the falling edge, clear of the launching edge
    always @(negedge ref_clk)
        if (storeWrite === 1'b1)
            writeCnt++;

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Host sends a frame while the reply is collected alongside it
    task automatic xact(input string cmd, input string exp);
        logic [7:0] q[$];
        logic [7:0] b;
        bit         seen;
        fork
            for (int i = 0; i < cmd.len(); i++) hostU.sendByte(cmd[i]);
            do
            begin
                hostU.getByte(b, seen);
                if (seen) q.push_back(b);
            end
            while (seen && b !== 8'h0D);
        join
        check(8'(q.size()), 8'(exp.len()));
        for (int i = 0; i < exp.len() && i < q.size(); i++) check(q[i], exp[i]);
        $display("Test done: %s", cmd);
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Reset with the given straps, then the settings that must be loaded
    task automatic boot(input logic sw, input logic valid, input logic [7:0] addr,
                        input logic [7:0] rate, input logic ck);
        rst_n <= 1'b0;
        defaultSwitch <= sw;
        storedValid <= valid;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(nodeAddr, addr);
        check(rateCode, rate);
        check({7'h00, checksumOn}, {7'h00, ck});
        check({7'h00, defaultMode}, {7'h00, sw});
        $display("Test done: reset");
    endtask

    // Scaled rates keep the whole run near twenty-four thousand cycles
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        error_cnt++;
        wrap_up();
    end

    // Host keeps uppercase and zero format bits apart from bit 6
    // host side of the commands
    initial
    begin
        inputLevels <= 8'h11;
        hostU.bitLen = BENCH_HZ / 9600;
        boot(1'b1, 1'b1, 8'h00, 8'h06, 1'b0);
        xact("%0000000800\015", "!00\015");
        check(rateCode, 8'h06);
        check({7'h00, txEnable}, 8'h01);
        repeat (hostU.bitLen) @(posedge ref_clk);
        check(rateCode, 8'h08);
        check({7'h00, txEnable}, 8'h00);
        check(storeRateCode, 8'h08);
        check(storeAddr, 8'h00);
        check({7'h00, storeChecksum}, 8'h00);
        check(8'(writeCnt), 8'h01);
        hostU.bitLen = BENCH_HZ / 38400;
        xact("$006\015", "!110000\015");
        @(posedge ref_clk) inputLevels <= 8'hA5;
        xact("Z$1$006\015", "!A50000\015");
        xact("$016\015", "");
        xact("$0067\015", "?00\015");
        xact("%0000010600\015", "?00\015");
        boot(1'b0, 1'b1, 8'h5A, 8'h07, 1'b1);
        hostU.bitLen = BENCH_HZ / 19200;
        xact("$5A6D0\015", "!A5000057\015");
        xact("$5A6D1\015", "");
        xact("%5A5A0006403B\015", "?5AB5\015");
        check(8'(writeCnt), 8'h01);
        boot(1'b0, 1'b0, 8'h01, 8'h06, 1'b0);
        wrap_up();
    end
endmodule
